//--- design/period_timer_8bit.v
// Contract
// - input clock is system clock divided by four
// - prescale select gives 1, 4 or 16
// - prescaler pulse increments count while running
// - count compared with period, match when equal
// - count returns to zero after match
// - each match advances postscaler
// - postscale ratio is field plus one
// - postscaler output sets period match flag
// - reset loads count zero, period all ones
// - count and period fully read and writable
// - run bit two starts and stops timer
// - count or control write clears both scalers
// - control write leaves count unchanged
//
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`include "period_timer_consts.vh"

module period_timer_8bit (
    // clock and reset
    input  wire                 sys_clk,
    input  wire                 resetn,
    // avalon-mm slave
    input  wire [`ADDR_W-1:0]   avs_address,
    input  wire                 avs_read,
    input  wire                 avs_write,
    input  wire [31:0]          avs_writedata,
    output reg  [31:0]          avs_readdata,
    output wire                 avs_waitrequest,
    // interrupt and flag
    output wire                 irq,
    output wire                 period_match_flag
);

    // architectural registers and their next values
    reg  [7:0]  timer_count_r;
    reg  [7:0]  timer_count_nxt;
    reg  [7:0]  period_value_r;
    reg  [7:0]  period_value_nxt;
    // bit 7 of control is absent and reads zero
    reg  [6:0]  timer_control_r;
    reg  [6:0]  timer_control_nxt;

    // divider and scaler counters
    reg  [1:0]  instr_div_r;
    reg  [1:0]  instr_div_nxt;
    reg  [3:0]  pre_cnt_r;
    reg  [3:0]  pre_cnt_nxt;
    reg  [3:0]  post_cnt_r;
    reg  [3:0]  post_cnt_nxt;

    // interrupt state
    reg         flag_r;
    reg         flag_nxt;
    reg         irq_en_r;
    reg         irq_en_nxt;

    // bus handshake and read path
    reg         ack_r;
    reg         ack_nxt;
    reg  [31:0] read_word_nxt;

    // decoded control fields
    reg  [3:0]  pre_tc;
    wire [1:0]  pre_code;
    wire [3:0]  post_sel;
    wire        running;

    // bus strobes
    wire        req;
    wire        acc;
    wire        commit;
    wire        wr_count;
    wire        wr_period;
    wire        wr_ctrl;
    wire        wr_clear;
    wire        wr_enable;

    // timing strobes
    wire        instr_tick;
    wire        pre_pulse;
    wire        match;
    wire        post_pulse;
    wire        scaler_clr;
    wire [7:0]  bit_equal;
    genvar      gi;

    // one wait state per access; the answer comes on the second edge
    // a request held past the answer is taken as a new one
    assign req             = avs_read | avs_write;
    assign acc             = req & ~ack_r;
    assign commit          = req & ack_r;
    assign avs_waitrequest = acc;

    // writes commit only at the edge where waitrequest is low
    // upper data bits are ignored on every register
    assign wr_count  = avs_write & commit & (avs_address == `ADDR_TIMER_COUNT);
    assign wr_period = avs_write & commit & (avs_address == `ADDR_PERIOD_VALUE);
    assign wr_ctrl   = avs_write & commit & (avs_address == `ADDR_TIMER_CONTROL);
    assign wr_clear  = avs_write & commit & (avs_address == `ADDR_IRQ_CLEAR);
    assign wr_enable = avs_write & commit & (avs_address == `ADDR_IRQ_ENABLE);

    // control fields
    assign running  = timer_control_r[`CTL_RUN_BIT];
    assign pre_code = timer_control_r[`CTL_PRE_MSB:`CTL_PRE_LSB];
    assign post_sel = timer_control_r[`CTL_POST_MSB:`CTL_POST_LSB];

    // count or control writes restart both scalers from zero
    assign scaler_clr = wr_count | wr_ctrl;

    // acknowledge follows an unanswered request by one cycle
    always @* begin
        ack_nxt = acc;
    end

    // acknowledge flop
    // waitrequest depends on this flop and the live request
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= ack_nxt;
        end
    end

    // read word chosen in the wait cycle; unmapped and clear read zero
    // captured early so the data stand at the answering edge
    always @* begin
        read_word_nxt = avs_readdata;
        if (acc && avs_read) begin
            case (avs_address)
                `ADDR_TIMER_COUNT:   read_word_nxt = {24'h0, timer_count_r};
                `ADDR_PERIOD_VALUE:  read_word_nxt = {24'h0, period_value_r};
                `ADDR_TIMER_CONTROL: read_word_nxt = {25'h0, timer_control_r};
                `ADDR_IRQ_STATUS:    read_word_nxt = {31'h0, flag_r};
                `ADDR_IRQ_ENABLE:    read_word_nxt = {31'h0, irq_en_r};
                default:             read_word_nxt = 32'h0000_0000;
            endcase
        end
    end

    // read data flop
    // holds until the next read
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_readdata <= read_word_nxt;
        end
    end

    // instruction clock: free running, never restarted by bus writes,
    // so the first prescaler pulse after a write lands 1 to 4 cycles late
    always @* begin
        instr_div_nxt = instr_div_r + 2'h1;
    end
    assign instr_tick = (instr_div_r == `INSTR_DIV);

    // instruction divider flop
    // phase is shared by all prescale settings
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            instr_div_r <= 2'h0;
        end else begin
            instr_div_r <= instr_div_nxt;
        end
    end

    // prescale terminal count; upper select bit alone picks divide by 16
    always @* begin
        pre_tc = `PRE_TC_1;
        case (pre_code)
            2'h0:    pre_tc = `PRE_TC_1;
            2'h1:    pre_tc = `PRE_TC_4;
            default: pre_tc = `PRE_TC_16;
        endcase
    end

    // prescaler next value; >= copes with a select change above the limit
    // only count and control writes and reset clear it; a stop, being a control write, clears it too
    always @* begin
        pre_cnt_nxt = pre_cnt_r;
        if (scaler_clr) begin
            pre_cnt_nxt = 4'h0;
        end else if (running && instr_tick) begin
            if (pre_cnt_r >= pre_tc) begin
                pre_cnt_nxt = 4'h0;
            end else begin
                pre_cnt_nxt = pre_cnt_r + 4'h1;
            end
        end
    end

    // prescaler output: one pulse per 1, 4 or 16 instruction ticks
    // stopping the timer freezes the count in place and clears the prescaler
    assign pre_pulse = running & instr_tick & ~scaler_clr & (pre_cnt_r >= pre_tc);

    // prescaler flop
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pre_cnt_r <= 4'h0;
        end else begin
            pre_cnt_r <= pre_cnt_nxt;
        end
    end

    // bitwise comparator, one equality cell per count bit
    // equality is checked every cycle, the action waits for a pulse
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_cmp
            assign bit_equal[gi] = ~(timer_count_r[gi] ^ period_value_r[gi]);
        end
    endgenerate
    assign match = &bit_equal;

    // count next value; a bus write beats a simultaneous increment
    // the wrap happens on the pulse after equality appeared
    always @* begin
        timer_count_nxt = timer_count_r;
        if (wr_count) begin
            timer_count_nxt = avs_writedata[7:0];
        end else if (pre_pulse) begin
            if (match) begin
                timer_count_nxt = 8'h00;
            end else begin
                timer_count_nxt = timer_count_r + 8'h01;
            end
        end
    end

    // period next value
    always @* begin
        period_value_nxt = period_value_r;
        if (wr_period) begin
            period_value_nxt = avs_writedata[7:0];
        end
    end

    // control next value; selects may change mid count, scalers restart
    always @* begin
        timer_control_nxt = timer_control_r;
        if (wr_ctrl) begin
            timer_control_nxt = avs_writedata[6:0];
        end
    end

    // count flop; control writes never reach it
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            timer_count_r <= `RST_TIMER_COUNT;
        end else begin
            timer_count_r <= timer_count_nxt;
        end
    end

    // period flop
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            period_value_r <= `RST_PERIOD_VALUE;
        end else begin
            period_value_r <= period_value_nxt;
        end
    end

    // control flop
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            timer_control_r <= `RST_TIMER_CONTROL;
        end else begin
            timer_control_r <= timer_control_nxt;
        end
    end

    // postscaler counts matches at the wrap to zero, not at first equality
    // a period of zero matches on every prescaler pulse
    always @* begin
        post_cnt_nxt = post_cnt_r;
        if (scaler_clr) begin
            post_cnt_nxt = 4'h0;
        end else if (pre_pulse && match) begin
            if (post_cnt_r >= post_sel) begin
                post_cnt_nxt = 4'h0;
            end else begin
                post_cnt_nxt = post_cnt_r + 4'h1;
            end
        end
    end

    // postscaler output every field-plus-one matches
    assign post_pulse = pre_pulse & match & (post_cnt_r >= post_sel);

    // postscaler flop
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            post_cnt_r <= 4'h0;
        end else begin
            post_cnt_r <= post_cnt_nxt;
        end
    end

    // sticky flag; a set in the same cycle as a clear wins
    // software clears it by writing one to the clear register
    always @* begin
        flag_nxt = flag_r;
        if (post_pulse) begin
            flag_nxt = 1'b1;
        end else if (wr_clear && avs_writedata[`IRQ_STAT_BIT]) begin
            flag_nxt = 1'b0;
        end
    end

    // enable mask, same layout as status
    // masking never stops the flag from setting
    always @* begin
        irq_en_nxt = irq_en_r;
        if (wr_enable) begin
            irq_en_nxt = avs_writedata[`IRQ_STAT_BIT];
        end
    end

    // flag flop
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // enable flop
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq_en_r <= 1'b0;
        end else begin
            irq_en_r <= irq_en_nxt;
        end
    end

    // level interrupt while an enabled status bit is set
    // the flag output shows the raw status, unmasked
    assign period_match_flag = flag_r;
    assign irq               = flag_r & irq_en_r;

endmodule // period_timer_8bit

//--- design/period_timer_consts.vh
`ifndef PERIOD_TIMER_CONSTS_VH
`define PERIOD_TIMER_CONSTS_VH
// register byte addresses (word aligned)
`define ADDR_TIMER_COUNT    5'h00
`define ADDR_PERIOD_VALUE   5'h04
`define ADDR_TIMER_CONTROL  5'h08
`define ADDR_IRQ_STATUS     5'h0c
`define ADDR_IRQ_CLEAR      5'h10
`define ADDR_IRQ_ENABLE     5'h14
// byte address width
`define ADDR_W              5
// reset values
`define RST_TIMER_COUNT     8'h00
`define RST_PERIOD_VALUE    8'hff
`define RST_TIMER_CONTROL   7'h00
// control field positions
`define CTL_PRE_LSB         0
`define CTL_PRE_MSB         1
`define CTL_RUN_BIT         2
`define CTL_POST_LSB        3
`define CTL_POST_MSB        6
// instruction clock is the system clock divided by four
`define INSTR_DIV           2'h3
// prescale terminal counts
`define PRE_TC_1            4'h0
`define PRE_TC_4            4'h3
`define PRE_TC_16           4'hf
// interrupt layout shared by status, clear and enable: match event at bit 0
`define IRQ_STAT_BIT        0
`endif

//--- verif/period_timer_8bit_bench.sv
`timescale 1ns/1ps
`include "period_timer_consts.vh"
module period_timer_8bit_bench;
    logic        sys_clk, resetn, avs_read, avs_write, avs_waitrequest, irq, period_match_flag;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, v;
    int          errors, checked, n, e, i;
    period_timer_8bit uut (.sys_clk(sys_clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .period_match_flag(period_match_flag));
    initial begin
        sys_clk = 0;
        forever #25 sys_clk = ~sys_clk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one bus cycle, held until waitrequest is seen low, then one idle edge
    // waitrequest and read data are taken at the rising edge itself
    task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int k;
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        v = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
        if (k >= 20) begin
            errors++;
            close_out;
        end
    endtask
    task rd_chk(input logic [4:0] a, input logic [31:0] exp);
        bus(0, a, 0);
        check(v, exp);
    endtask
    task t_regs;
        rd_chk(`ADDR_TIMER_COUNT, 32'h0);
        rd_chk(`ADDR_PERIOD_VALUE, 32'hff);
        bus(1, `ADDR_TIMER_COUNT, 32'h5a);
        bus(1, `ADDR_TIMER_CONTROL, 32'hfb);
        rd_chk(`ADDR_TIMER_CONTROL, 32'h7b);
        rd_chk(`ADDR_TIMER_COUNT, 32'h5a);
        bus(1, `ADDR_TIMER_CONTROL, 32'h4);
        bus(1, `ADDR_TIMER_COUNT, 32'ha0);
        repeat (16) @(posedge sys_clk);
        bus(0, `ADDR_TIMER_COUNT, 0);
        check(v >= 32'ha3 && v <= 32'ha6, 1);
        bus(1, `ADDR_TIMER_CONTROL, 32'h0);
        bus(0, `ADDR_TIMER_COUNT, 0);
        repeat (40) @(posedge sys_clk);
        rd_chk(`ADDR_TIMER_COUNT, v);
        $display("registers done");
    endtask
    // period 3, so one match per four prescaler pulses
    task t_ratio(input logic [1:0] pc, input int pd, input logic [3:0] qc);
        bus(1, `ADDR_PERIOD_VALUE, 32'h3);
        bus(1, `ADDR_TIMER_COUNT, 32'h0);
        bus(1, `ADDR_IRQ_CLEAR, 32'h1);
        bus(1, `ADDR_IRQ_ENABLE, 32'h1);
        bus(1, `ADDR_TIMER_CONTROL, {25'h0, qc, 1'b1, pc});
        n = 0;
        while (period_match_flag !== 1'b1 && n < 5000) begin
            @(negedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        e = 16 * pd * (qc + 1);
        check(n + 8 > e && n < e + 8, 1);
        if (n >= 5000) close_out;
        check(irq, 1);
        rd_chk(`ADDR_IRQ_STATUS, 32'h1);
        bus(1, `ADDR_TIMER_CONTROL, 32'h0);
        bus(1, `ADDR_IRQ_ENABLE, 32'h0);
        check({irq, period_match_flag}, 2'b01);
        bus(1, `ADDR_IRQ_CLEAR, 32'h1);
        check(period_match_flag, 0);
        $display("ratio %0d %0d done", pd, qc + 1);
    endtask
    // reset in mid-run returns count, period and control to their reset values
    task t_reset;
        bus(1, `ADDR_PERIOD_VALUE, 32'h3c);
        bus(1, `ADDR_TIMER_CONTROL, 32'h4);
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        rd_chk(`ADDR_TIMER_COUNT, 32'h0);
        rd_chk(`ADDR_PERIOD_VALUE, 32'hff);
        rd_chk(`ADDR_TIMER_CONTROL, 32'h0);
        $display("reset done");
    endtask
    initial begin
        {resetn, avs_read, avs_write, avs_address, avs_writedata} = 0;
        repeat (3) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        t_regs;
        t_ratio(2'h0, 1, 4'h0);
        t_ratio(2'h1, 4, 4'h1);
        t_ratio(2'h2, 16, 4'h0);
        t_ratio(2'h3, 16, 4'hf);
        t_reset;
        close_out;
    end
endmodule // period_timer_8bit_bench

//--- verif/period_timer_checker.sv
`timescale 1ns/1ps
module period_timer_checker (
    // clock and reset
    input wire        sys_clk,
    input wire        resetn,
    // bus
    input wire [4:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    // interrupt
    input wire        irq,
    input wire        period_match_flag
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic run_r;
    wire req = avs_read | avs_write;
    wire acc = req & !avs_waitrequest;
    wire clr = acc & avs_write & (avs_address == 5'h10) & avs_writedata[0];
    // run bit shadowed from bus writes, the port list has no view of it
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            run_r <= 1'b0;
        else if (acc & avs_write & (avs_address == 5'h08))
            run_r <= avs_writedata[2];
    end
    a_wait_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer one cycle after request");
    a_wait_idle: assert property (!req |-> !avs_waitrequest)
        else $error("wait raised with no request");
    a_irq_needs_flag: assert property (irq |-> period_match_flag)
        else $error("irq without flag");
    a_flag_sticky: assert property (period_match_flag && !clr |=> period_match_flag)
        else $error("flag dropped by itself");
    a_stop_quiet: assert property ((!run_r)[*4] |-> !$rose(period_match_flag))
        else $error("flag rose while stopped");
    a_count_width: assert property (acc && avs_read && avs_address == 5'h00 |-> avs_readdata[31:8] == 24'h0)
        else $error("count read too wide");
    a_ctl_upper_zero: assert property (acc && avs_read && avs_address == 5'h08 |-> avs_readdata[31:7] == 25'h0)
        else $error("control upper bits set");
    a_read_holds: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without read");
    c_clear: cover property (clr);
    c_irq: cover property ($rose(irq));
    c_stopped: cover property ((!run_r)[*4]);
endmodule // period_timer_checker

bind period_timer_8bit period_timer_checker chk (.sys_clk(sys_clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .period_match_flag(period_match_flag));
